// >>> pkg/dmt_pkg.sv
// package: register map, field positions, keys and reset values of the deadman timer
package dmt_pkg;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned KEY_W = 8;
    localparam int unsigned ADDR_W = 4;

    // --------------------------------------------------------------
    // register offsets (word index on the register port)
    // --------------------------------------------------------------
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_PRECLEAR = 4'h1;
    localparam logic [3:0] OFS_CLEAR = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_CNT_LOW = 4'h4;
    localparam logic [3:0] OFS_CNT_HIGH = 4'h5;
    localparam logic [3:0] OFS_TMO_LOW = 4'h6;
    localparam logic [3:0] OFS_TMO_HIGH = 4'h7;
    localparam logic [3:0] OFS_INTV_LOW = 4'h8;
    localparam logic [3:0] OFS_INTV_HIGH = 4'h9;
    localparam logic [3:0] OFS_HOLD = 4'hA;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int unsigned ON_BIT = 15;
    localparam int unsigned PRE_LSB = 8;
    localparam int unsigned CLR_LSB = 0;
    localparam int unsigned BAD_PRE_BIT = 7;
    localparam int unsigned BAD_CLR_BIT = 6;
    localparam int unsigned EVENT_BIT = 5;
    localparam int unsigned WIN_BIT = 0;

    // --------------------------------------------------------------
    // keys and reset values
    // --------------------------------------------------------------
    localparam logic [7:0] PRECLEAR_KEY = 8'h40;
    localparam logic [7:0] CLEAR_KEY = 8'h08;
    localparam logic [7:0] KEY_RST = 8'h00;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;

    function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] ofs);
        return addr == ofs;
    endfunction : addr_hit
endpackage : dmt_pkg

// >>> pkg/dmt_cnt_if.sv
// interface: control and state between the register block and the fetch counter
interface dmt_cnt_if;
    logic run_en;
    logic fetch;
    logic sleep;
    logic clear;
    logic [31:0] timeout;
    logic [31:0] interval;
    logic [31:0] count;
    logic expired;
    logic win_open;

    modport ctl (
        output run_en, fetch, sleep, clear, timeout, interval,
        input count, expired, win_open
    );
    modport cnt (
        input run_en, fetch, sleep, clear, timeout, interval,
        output count, expired, win_open
    );
endinterface : dmt_cnt_if

// >>> rtl/dmt_fetch_counter.sv
// fetch counter: counts instruction fetches up to the timeout match value
module dmt_fetch_counter (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    dmt_cnt_if.cnt c
);
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic step;

    // no fetches in sleep, and counting stops at the match
    assign step = c.run_en & c.fetch & ~c.sleep & ~c.expired;
    assign count_nxt = count_r + 32'h0000_0001;
    assign c.count = count_r;
    assign c.expired = (count_r == c.timeout);
    assign c.win_open = (count_r >= c.interval);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            count_r <= dmt_pkg::CNT_RST;
        end else if (c.clear) begin
            count_r <= dmt_pkg::CNT_RST;
        end else if (step) begin
            count_r <= count_nxt;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_cnt_step;
        c.run_en && c.fetch && !c.sleep && !c.expired && !c.clear
            |=> count_r == $past(count_r) + 32'h0000_0001;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter missed a fetch");

    property p_cnt_sleep;
        c.sleep && !c.clear |=> $stable(count_r);
    endproperty
    a_cnt_sleep: assert property (p_cnt_sleep) else $error("counter moved in sleep");

    property p_cnt_stop;
        c.run_en && c.expired && !c.clear |=> c.expired && $stable(count_r);
    endproperty
    a_cnt_stop: assert property (p_cnt_stop) else $error("counter ran past match");

    property p_win;
        c.clear |=> (c.win_open == (c.interval == 32'h0000_0000));
    endproperty
    a_win: assert property (p_win) else $error("window open after clear");
endmodule : dmt_fetch_counter

// >>> rtl/dmt_deadman_timer.sv
// deadman timer: key-sequenced clear, status, fuse mirrors and fetch counter
//
// Notes on behaviour
// - 32-bit counter advances per fetch until match
// - no counting while the processor sleeps
// - timeout match comes from two fuse halves
// - enabled by fuse or by software bit
// - software bit only works if fuse_disable low
// - enable bit 15 is set-only by software, resets low, clears on reset event
// - key 0x40 in bits 15-8 arms preclear
// - other preclear pattern sets bad_preclear_flag
// - preclear field clears on reset event, good clear
// - key 0x08 after preclear clears counter, keys
// - counter reads show restart after good clear
// - wrong clear key: flag, keep preclear, store
// - bad flags in status bits 7, 6
// - event flag bit 5 on expiry or bad key while enabled
// - status bit 0 shows clear window open
// - event drives interrupt to processor
// - live counter read as two 16-bit halves
// - hold register loads upper half on counter read
// - timeout and interval mirrored in status registers
module dmt_deadman_timer (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic fetch_i,
    input wire logic sleep_i,
    input wire logic timer_reset_i,
    input wire logic fuse_enable_i,
    input wire logic fuse_disable_i,
    input wire logic [15:0] timeout_fuse_low_i,
    input wire logic [15:0] timeout_fuse_high_i,
    input wire logic [15:0] interval_fuse_low_i,
    input wire logic [15:0] interval_fuse_high_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic event_irq_o
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic fuse_ld_r;
    logic fen_r;
    logic fdis_r;
    logic [31:0] timeout_r;
    logic [31:0] interval_r;
    logic on_r;
    logic [7:0] pre_r;
    logic [7:0] clr_r;
    logic bad_pre_r;
    logic bad_clr_r;
    logic evt_r;
    logic [15:0] hold_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    dmt_cnt_if c ();

    dmt_fetch_counter u_cnt (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .c(c.cnt)
    );

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    logic wr_ctl;
    logic wr_pre;
    logic wr_clr;
    logic rd_cnt;
    logic [7:0] pre_key;
    logic [7:0] clr_key;
    logic pre_ok;
    logic clr_good;
    logic pre_bad;
    logic clr_bad;
    logic run_en;
    logic evt_set;
    logic [15:0] ctl_w;
    logic [15:0] pre_w;
    logic [15:0] clr_w;
    logic [15:0] stat_w;

    assign wr_ctl = wr_i & dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_CONTROL);
    assign wr_pre = wr_i & dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_PRECLEAR);
    assign wr_clr = wr_i & dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_CLEAR);
    assign rd_cnt = rd_i & (dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_CNT_LOW)
                    | dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_CNT_HIGH));
    assign pre_key = wdata_i[dmt_pkg::PRE_LSB +: dmt_pkg::KEY_W];
    assign clr_key = wdata_i[dmt_pkg::CLR_LSB +: dmt_pkg::KEY_W];
    assign pre_ok = (pre_key == dmt_pkg::PRECLEAR_KEY);
    // clear key counts only when the preclear is armed
    assign clr_good = wr_clr & (clr_key == dmt_pkg::CLEAR_KEY)
                      & (pre_r == dmt_pkg::PRECLEAR_KEY);
    assign pre_bad = wr_pre & ~pre_ok;
    assign clr_bad = wr_clr & ~clr_good;

    // fuse enables outright; software bit counts only without fuse disable
    assign run_en = fuse_ld_r & (fen_r | (~fdis_r & on_r));
    assign evt_set = run_en & (c.expired | pre_bad | clr_bad);

    assign c.run_en = run_en;
    assign c.fetch = fetch_i;
    assign c.sleep = sleep_i;
    assign c.clear = clr_good | timer_reset_i;
    assign c.timeout = timeout_r;
    assign c.interval = interval_r;

    // --------------------------------------------------------------
    // fuse capture after reset release
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fuse_ld_r <= 1'b0;
            fen_r <= 1'b0;
            fdis_r <= 1'b0;
            timeout_r <= dmt_pkg::CNT_RST;
            interval_r <= dmt_pkg::CNT_RST;
        end else if (!fuse_ld_r) begin
            fuse_ld_r <= 1'b1;
            fen_r <= fuse_enable_i;
            fdis_r <= fuse_disable_i;
            timeout_r <= {timeout_fuse_high_i, timeout_fuse_low_i};
            interval_r <= {interval_fuse_high_i, interval_fuse_low_i};
        end
    end

    // --------------------------------------------------------------
    // control and keys
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            on_r <= 1'b0;
        end else if (wr_ctl && wdata_i[dmt_pkg::ON_BIT]) begin
            on_r <= 1'b1;
        end else if (timer_reset_i) begin
            on_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pre_r <= dmt_pkg::KEY_RST;
        end else if (wr_pre) begin
            pre_r <= pre_key;
        end else if (clr_good || timer_reset_i) begin
            pre_r <= dmt_pkg::KEY_RST;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            clr_r <= dmt_pkg::KEY_RST;
        end else if (clr_good) begin
            clr_r <= dmt_pkg::KEY_RST;
        end else if (wr_clr) begin
            clr_r <= clr_key;
        end else if (timer_reset_i) begin
            clr_r <= dmt_pkg::KEY_RST;
        end
    end

    // --------------------------------------------------------------
    // status flags: set wins over the hardware clear
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bad_pre_r <= 1'b0;
            bad_clr_r <= 1'b0;
            evt_r <= 1'b0;
        end else begin
            bad_pre_r <= pre_bad | (bad_pre_r & ~timer_reset_i);
            bad_clr_r <= clr_bad | (bad_clr_r & ~timer_reset_i);
            evt_r <= evt_set | (evt_r & ~timer_reset_i);
        end
    end

    assign event_irq_o = evt_r;

    // --------------------------------------------------------------
    // hold register and read port
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            hold_r <= dmt_pkg::REG_RST;
        end else if (rd_cnt) begin
            hold_r <= c.count[31:16];
        end
    end

    assign ctl_w = 16'(on_r) << dmt_pkg::ON_BIT;
    assign pre_w = 16'(pre_r) << dmt_pkg::PRE_LSB;
    assign clr_w = 16'(clr_r) << dmt_pkg::CLR_LSB;
    assign stat_w = (16'(bad_pre_r) << dmt_pkg::BAD_PRE_BIT)
                    | (16'(bad_clr_r) << dmt_pkg::BAD_CLR_BIT)
                    | (16'(evt_r) << dmt_pkg::EVENT_BIT)
                    | (16'(c.win_open) << dmt_pkg::WIN_BIT);

    assign rdata_nxt =
        !rd_i ? dmt_pkg::REG_RST :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_CONTROL) ? ctl_w :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_PRECLEAR) ? pre_w :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_CLEAR) ? clr_w :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_STATUS) ? stat_w :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_CNT_LOW) ? c.count[15:0] :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_CNT_HIGH) ? c.count[31:16] :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_TMO_LOW) ? timeout_r[15:0] :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_TMO_HIGH) ? timeout_r[31:16] :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_INTV_LOW) ? interval_r[15:0] :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_INTV_HIGH) ? interval_r[31:16] :
        dmt_pkg::addr_hit(addr_i, dmt_pkg::OFS_HOLD) ? hold_r :
        dmt_pkg::REG_RST;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= dmt_pkg::REG_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_fuse_dis;
        fuse_ld_r && fdis_r && !fen_r |-> !run_en;
    endproperty
    a_fuse_dis: assert property (p_fuse_dis) else $error("enable bit acted under fuse disable");

    property p_on_sticky;
        on_r && !timer_reset_i |=> on_r;
    endproperty
    a_on_sticky: assert property (p_on_sticky) else $error("enable bit was cleared");

    property p_pre_arm;
        wr_pre && pre_key == dmt_pkg::PRECLEAR_KEY
            |=> pre_r == dmt_pkg::PRECLEAR_KEY && !$rose(bad_pre_r);
    endproperty
    a_pre_arm: assert property (p_pre_arm) else $error("preclear key not armed");

    property p_bad_pre;
        wr_pre && pre_key != dmt_pkg::PRECLEAR_KEY
            |=> bad_pre_r ##1 (rdata_o[7] || !$past(rd_i && addr_i == dmt_pkg::OFS_STATUS));
    endproperty
    a_bad_pre: assert property (p_bad_pre) else $error("bad preclear not flagged");

    property p_good_clear;
        wr_clr && clr_key == dmt_pkg::CLEAR_KEY && pre_r == dmt_pkg::PRECLEAR_KEY
            |=> pre_r == dmt_pkg::KEY_RST && clr_r == dmt_pkg::KEY_RST && c.count == 32'h0;
    endproperty
    a_good_clear: assert property (p_good_clear) else $error("good clear failed");

    property p_bad_clr;
        clr_bad && !timer_reset_i
            |=> bad_clr_r && pre_r == $past(pre_r) && clr_r == $past(clr_key);
    endproperty
    a_bad_clr: assert property (p_bad_clr) else $error("bad clear handled wrongly");

    property p_stat_rd;
        rd_i && addr_i == dmt_pkg::OFS_STATUS
            |=> rdata_o[7] == $past(bad_pre_r) && rdata_o[6] == $past(bad_clr_r)
                && rdata_o[5] == $past(evt_r) && rdata_o[0] == $past(c.win_open);
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status read mismatch");

    property p_expire_irq;
        run_en && c.expired |=> event_irq_o ##1 (event_irq_o || $past(timer_reset_i));
    endproperty
    a_expire_irq: assert property (p_expire_irq) else $error("expiry gave no interrupt");

    property p_hold;
        rd_cnt |=> hold_r == $past(c.count[31:16]);
    endproperty
    a_hold: assert property (p_hold) else $error("hold register not loaded");

    property p_tmo_rd;
        rd_i && addr_i == dmt_pkg::OFS_TMO_HIGH |=> rdata_o == $past(timeout_r[31:16]);
    endproperty
    a_tmo_rd: assert property (p_tmo_rd) else $error("timeout mirror mismatch");

    property p_treset;
        timer_reset_i && !wr_i && !evt_set
            |=> !bad_pre_r && !bad_clr_r && !evt_r && pre_r == dmt_pkg::KEY_RST;
    endproperty
    a_treset: assert property (p_treset) else $error("timer reset left state");

    property p_pre_clear;
        clr_good || (timer_reset_i && !wr_pre) |=> pre_r == dmt_pkg::KEY_RST;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("preclear field kept");

    property p_pre_store;
        pre_bad |=> pre_r == $past(pre_key);
    endproperty
    a_pre_store: assert property (p_pre_store) else $error("bad preclear not stored");

    property p_ctl_keep;
        wr_ctl && !wdata_i[dmt_pkg::ON_BIT] && !timer_reset_i |=> on_r == $past(on_r);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep) else $error("enable bit cleared");

    property p_fuse_en;
        fuse_ld_r && fen_r |-> run_en;
    endproperty
    a_fuse_en: assert property (p_fuse_en) else $error("fuse enable ignored");

    property p_bad_evt;
        run_en && (pre_bad || clr_bad) |=> evt_r;
    endproperty
    a_bad_evt: assert property (p_bad_evt) else $error("bad key gave no event");

    property p_lo_rd;
        rd_i && addr_i == dmt_pkg::OFS_CNT_LOW |=> rdata_o == $past(c.count[15:0]);
    endproperty
    a_lo_rd: assert property (p_lo_rd) else $error("counter low read wrong");

    property p_hi_rd;
        rd_i && addr_i == dmt_pkg::OFS_CNT_HIGH |=> rdata_o == $past(c.count[31:16]);
    endproperty
    a_hi_rd: assert property (p_hi_rd) else $error("counter high read wrong");

    property p_hold_keep;
        !rd_cnt |=> $stable(hold_r);
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("hold loaded unasked");

    property p_treset_cnt;
        timer_reset_i && !wr_ctl |=> !on_r && c.count == dmt_pkg::CNT_RST;
    endproperty
    a_treset_cnt: assert property (p_treset_cnt) else $error("count kept on reset");

    c_good_clear: cover property (wr_pre && pre_ok ##[1:4] clr_good);
    c_bad_pre: cover property (pre_bad && run_en);
    c_expire: cover property (run_en && c.expired);
    c_hold: cover property (rd_cnt ##1 rd_i && addr_i == dmt_pkg::OFS_HOLD);
    c_treset: cover property (timer_reset_i && evt_r);
endmodule : dmt_deadman_timer

// >>> sim/dmt_core_model.sv
// core model: instruction fetch, sleep and deadman reset event toward the timer
module dmt_core_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic slow_i,
    input wire logic sleep_req_i,
    input wire logic reset_req_i,
    output logic fetch_o,
    output logic sleep_o,
    output logic timer_reset_o,
    output logic [31:0] fetch_count_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic phase_r;

    // --------------------------------------------------------------
    // fetch stream
    // --------------------------------------------------------------
    // fetch line stays up in sleep on purpose, so the timer's own gate is exercised
    assign fetch_o = run_i & (~slow_i | phase_r);
    assign sleep_o = sleep_req_i;
    assign timer_reset_o = reset_req_i;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            phase_r <= 1'b0;
            fetch_count_o <= 32'h0000_0000;
        end else begin
            phase_r <= ~phase_r;
            // only fetches outside sleep are real ones
            if (fetch_o & ~sleep_o) begin
                fetch_count_o <= fetch_count_o + 32'h0000_0001;
            end
        end
    end
endmodule : dmt_core_model

// >>> sim/deadman_fetch_timer_bench.sv
// testbench: register tests of the deadman fetch timer through its register port
module deadman_fetch_timer_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys_i;
    logic rst_i;
    logic fuse_en, fuse_dis;
    logic [15:0] tmo_lo, tmo_hi, iv_lo, iv_hi;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic wr, rd, irq;
    logic run, slow, sleep_req, reset_req;
    logic fetch, sleep, treset;
    logic [31:0] fcount, fcount0;
    int fails;
    int check_count;
    logic [15:0] rst_exp [12];

    dmt_deadman_timer dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .fetch_i(fetch), .sleep_i(sleep),
        .timer_reset_i(treset), .fuse_enable_i(fuse_en), .fuse_disable_i(fuse_dis),
        .timeout_fuse_low_i(tmo_lo), .timeout_fuse_high_i(tmo_hi),
        .interval_fuse_low_i(iv_lo), .interval_fuse_high_i(iv_hi),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .event_irq_o(irq)
    );

    dmt_core_model core (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run), .slow_i(slow),
        .sleep_req_i(sleep_req), .reset_req_i(reset_req), .fetch_o(fetch),
        .sleep_o(sleep), .timer_reset_o(treset), .fetch_count_o(fcount)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // --------------------------------------------------------------
    // bus and check tasks
    // --------------------------------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk16

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
    endtask : bus_wr

    task automatic bus_idle();
        @(posedge clk_sys_i);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus_idle

    task automatic bus_rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        rd <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        chk16(rdata, exp, $sformatf("read %h", a));
    endtask : bus_rd

    task automatic fetch_n(input int n);
        bus_idle();
        run <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        run <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask : fetch_n

    task automatic pulse_timer_reset();
        bus_idle();
        reset_req <= 1'b1;
        @(posedge clk_sys_i);
        reset_req <= 1'b0;
    endtask : pulse_timer_reset

    task automatic do_reset(input logic en, input logic dis, input logic [15:0] tl,
                            input logic [15:0] th, input logic [15:0] il, input logic [15:0] ih);
        @(posedge clk_sys_i);
        fuse_en <= en;
        fuse_dis <= dis;
        tmo_lo <= tl;
        tmo_hi <= th;
        iv_lo <= il;
        iv_hi <= ih;
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask : do_reset

    task automatic clear_seq();
        bus_wr(dmt_pkg::OFS_PRECLEAR, 16'h4000);
        bus_wr(dmt_pkg::OFS_CLEAR, 16'h0008);
    endtask : clear_seq

    task automatic end_test(input string name);
        $display("test %s done, checks %0d, mismatches %0d", name, check_count, fails);
    endtask : end_test

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // --------------------------------------------------------------
    // hang guard
    // --------------------------------------------------------------
    initial begin
        #200us;
        fails++;
        finish_test();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        fuse_en = 1'b0;
        fuse_dis = 1'b0;
        tmo_lo = 16'h0000;
        tmo_hi = 16'h0000;
        iv_lo = 16'h0000;
        iv_hi = 16'h0000;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        run = 1'b0;
        slow = 1'b0;
        sleep_req = 1'b0;
        reset_req = 1'b0;
        fails = 0;
        check_count = 0;
        rst_exp = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                    16'h1234, 16'h0001, 16'h0100, 16'h0002, 16'h0000, 16'h0000};

        // software enable, keys and flags
        do_reset(1'b0, 1'b0, 16'h1234, 16'h0001, 16'h0100, 16'h0002);
        for (int i = 0; i < 12; i++) begin
            bus_rd(4'(i), rst_exp[i]);
        end
        fetch_n(5);
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'h0000);
        bus_wr(dmt_pkg::OFS_CONTROL, 16'h8000);
        bus_wr(dmt_pkg::OFS_CONTROL, 16'h0000);
        bus_rd(dmt_pkg::OFS_CONTROL, 16'h8000);
        fetch_n(6);
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'h0006);
        bus_rd(dmt_pkg::OFS_CNT_HIGH, 16'h0000);
        bus_rd(dmt_pkg::OFS_HOLD, 16'h0000);
        sleep_req <= 1'b1;
        fetch_n(4);
        sleep_req <= 1'b0;
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'h0006);
        clear_seq();
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'h0000);
        bus_rd(dmt_pkg::OFS_PRECLEAR, 16'h0000);
        bus_rd(dmt_pkg::OFS_CLEAR, 16'h0000);
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0000);
        bus_wr(dmt_pkg::OFS_CLEAR, 16'h0008);
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0060);
        chk16({15'h0000, irq}, 16'h0001, "irq");
        bus_rd(dmt_pkg::OFS_CLEAR, 16'h0008);
        bus_wr(dmt_pkg::OFS_PRECLEAR, 16'h1200);
        bus_rd(dmt_pkg::OFS_STATUS, 16'h00E0);
        bus_rd(dmt_pkg::OFS_PRECLEAR, 16'h1200);
        bus_wr(dmt_pkg::OFS_PRECLEAR, 16'h4000);
        bus_wr(dmt_pkg::OFS_CLEAR, 16'h0055);
        bus_rd(dmt_pkg::OFS_PRECLEAR, 16'h4000);
        bus_rd(dmt_pkg::OFS_CLEAR, 16'h0055);
        pulse_timer_reset();
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0000);
        bus_rd(dmt_pkg::OFS_PRECLEAR, 16'h0000);
        bus_rd(dmt_pkg::OFS_CLEAR, 16'h0000);
        bus_rd(dmt_pkg::OFS_CONTROL, 16'h0000);
        chk16({15'h0000, irq}, 16'h0000, "irq");
        end_test("keys");

        // fuse disable overrides the software bit
        do_reset(1'b0, 1'b1, 16'h1234, 16'h0001, 16'h0100, 16'h0002);
        bus_wr(dmt_pkg::OFS_CONTROL, 16'h8000);
        fetch_n(4);
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'h0000);
        bus_wr(dmt_pkg::OFS_PRECLEAR, 16'h1200);
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0080);
        end_test("fuse_disable");

        // fuse enable, window and expiry
        do_reset(1'b1, 1'b0, 16'h0008, 16'h0000, 16'h0003, 16'h0000);
        fetch_n(2);
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0000);
        fetch_n(1);
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0001);
        fetch_n(20);
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'h0008);
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0021);
        chk16({15'h0000, irq}, 16'h0001, "irq");
        clear_seq();
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'h0000);
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0020);
        fcount0 = fcount;
        slow <= 1'b1;
        fetch_n(6);
        slow <= 1'b0;
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'(fcount - fcount0));
        pulse_timer_reset();
        bus_rd(dmt_pkg::OFS_STATUS, 16'h0000);
        bus_rd(dmt_pkg::OFS_CNT_LOW, 16'h0000);
        end_test("expiry");
        finish_test();
    end
endmodule : deadman_fetch_timer_bench
